// File: rsm_consts.svh
// Constants of the reset phase sequencer
`ifndef RSM_CONSTS_SVH
`define RSM_CONSTS_SVH
`define RSM_SHORT_DELAY_CYCLES 13'h0100
`define RSM_LONG_DELAY_CYCLES 13'h1000
`define RSM_FETCH_CYCLES 2'h2
`define RSM_VECTOR_LOW_ADDR 16'hFFFE
`define RSM_VECTOR_HIGH_ADDR 16'hFFFF
`define RSM_CLK_PERIOD_NS 25
`define RSM_WDG_PULSE_NS 500
`define RSM_WDG_PULSE_CYCLES ((`RSM_WDG_PULSE_NS + `RSM_CLK_PERIOD_NS - 1) / `RSM_CLK_PERIOD_NS)
`define RSM_EXT_MIN_NS 75
`define RSM_EXT_MIN_CYCLES ((`RSM_EXT_MIN_NS + `RSM_CLK_PERIOD_NS - 1) / `RSM_CLK_PERIOD_NS)
`endif

// File: rsm_pkg.sv
// Types of the reset phase sequencer
package rsm_pkg;
   typedef enum logic [1:0] {
      RSM_ACTIVE = 2'b00,
      RSM_DELAY = 2'b01,
      RSM_FETCH = 2'b10,
      RSM_RUN = 2'b11
   } rsm_phase_t;
   typedef enum logic [1:0] {
      RSM_SRC_NONE = 2'b00,
      RSM_SRC_EXT = 2'b01,
      RSM_SRC_LVD = 2'b10,
      RSM_SRC_WDG = 2'b11
   } rsm_source_t;
endpackage

// File: rsm_req_sync.sv
// Asynchronous reset request capture and release synchroniser
`timescale 1ns/1ps
module rsm_req_sync (
   input wire logic sys_clk_in,
   input wire logic async_req_n_in,
   output logic req_sync_out
);
   logic stage1_reg;
   logic stage2_reg;

   // Request asserts at once, even with the clock stopped
   always_ff @(posedge sys_clk_in or negedge async_req_n_in) begin
      if (!async_req_n_in) begin
         stage1_reg <= 1'b1;
         stage2_reg <= 1'b1;
      end else begin
         stage1_reg <= 1'b0;
         stage2_reg <= stage1_reg;
      end
   end

   assign req_sync_out = stage2_reg;
endmodule

// File: rsm_reset_phase_sequencer.sv
// Reset phase sequencer: sources, active, delay and vector fetch phases
// Summary of operation
// RULE1 - External pulse, low-voltage detector and watchdog all act on reset pin.
// RULE2 - Every reset runs active phase, then stabilisation delay, then vector fetch.
// RULE3 - Delay is 256 or 4096 clocks, chosen by a non-volatile option.
// RULE4 - Integrator picks delay length to suit the external oscillator.
// RULE5 - Reset pin held low during the whole stabilisation delay.
// RULE6 - Vector fetch lasts exactly 2 clock cycles after the delay.
// RULE7 - Execution starts at the routine pointed to by FFFEh-FFFFh.
// RULE8 - Reset pin is input plus open-drain output with weak pull-up.
// RULE9 - External low pulse recognised above minimum width, detected asynchronously.
// RULE10 - Low-voltage detector gives power-on and voltage-drop resets.
// RULE11 - Pin driven low while supply is below detector threshold.
// RULE12 - Watchdog underflow drives pin low for at least minimum pulse width.
// RULE13 - Asynchronous request release synchronised before delay counting.
// RULE14 - New request during delay or fetch restarts from active phase; pin requests are masked in delay and first fetch cycle.
`timescale 1ns/1ps
`include "rsm_consts.svh"
module rsm_reset_phase_sequencer (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic reset_pin_in,
   output logic reset_pin_out,
   output logic reset_pin_oe_out,
   input wire logic low_voltage_detector_in,
   input wire logic lvd_power_on_in,
   input wire logic watchdog_underflow_in,
   input wire logic long_delay_option_in,
   output logic cpu_reset_out,
   output logic vector_fetch_out,
   output logic [15:0] fetch_addr_out,
   output rsm_pkg::rsm_phase_t phase_out,
   output rsm_pkg::rsm_source_t source_out
);
   import rsm_pkg::*;

   localparam logic [12:0] WDG_PULSE = 13'(`RSM_WDG_PULSE_CYCLES);

   rsm_phase_t phase_reg;
   rsm_source_t source_reg;
   logic [12:0] count_reg;
   logic [12:0] wdg_count_reg;
   logic [1:0] fetch_count_reg;
   logic [15:0] fetch_addr_reg;
   logic pin_drive_reg;
   logic wdg_hold;
   logic ext_async_n;
   logic ext_req;
   logic int_req;
   logic any_req;
   logic drive_mask_reg;
   logic delay_end;

   // Last cycle of the stabilisation delay; shared by phase, fetch and pin logic
   function automatic logic is_delay_end(input rsm_phase_t ph, input logic [12:0] cnt);
      is_delay_end = (ph == RSM_DELAY) && (cnt == 13'h0001);
   endfunction

   // Phases in which the device itself pulls the pin low [RULE5]
   function automatic logic holds_pin(input rsm_phase_t ph, input logic [12:0] cnt);
      case (ph)
         RSM_ACTIVE: holds_pin = 1'b1;
         RSM_DELAY: holds_pin = !is_delay_end(ph, cnt);
         default: holds_pin = 1'b0;
      endcase
   endfunction

   // Option read only as the active phase ends; a change mid-delay waits a reset [RULE3]
   function automatic logic [12:0] delay_load(input logic long_sel);
      if (long_sel) begin
         delay_load = `RSM_LONG_DELAY_CYCLES;
      end else begin
         delay_load = `RSM_SHORT_DELAY_CYCLES;
      end
   endfunction

   // Pin low from outside, or reset itself, requests asynchronously [RULE9]
   // Own drive and the cycle after it are masked, else our own low would retrigger us
   assign ext_async_n = (reset_pin_in | pin_drive_reg | drive_mask_reg) & reset_n_in;

   rsm_req_sync u_ext_sync (
      .sys_clk_in(sys_clk_in),
      .async_req_n_in(ext_async_n),
      .req_sync_out(ext_req)
   );

   // Watchdog pulse stretcher [RULE12]
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wdg_count_reg <= 13'h0000;
      end else if (watchdog_underflow_in) begin
         wdg_count_reg <= WDG_PULSE;
      end else if (wdg_count_reg != 13'h0000) begin
         wdg_count_reg <= wdg_count_reg - 13'h0001;
      end
   end

   assign wdg_hold = watchdog_underflow_in | (wdg_count_reg != 13'h0000);
   // All three sources merge into one request [RULE1] [RULE10] [RULE11]
   assign int_req = low_voltage_detector_in | wdg_hold;
   assign any_req = ext_req | int_req;
   assign delay_end = is_delay_end(phase_reg, count_reg);

   // Phase register; synchronised request release starts the sequence [RULE2] [RULE13]
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         phase_reg <= RSM_ACTIVE;
      end else if (any_req) begin
         // Restart on any new request [RULE14]
         phase_reg <= RSM_ACTIVE;
      end else begin
         case (phase_reg)
            RSM_ACTIVE: begin
               phase_reg <= RSM_DELAY;
            end

            RSM_DELAY: begin
               if (delay_end) begin
                  phase_reg <= RSM_FETCH;
               end
            end

            RSM_FETCH: begin
               // Exactly two fetch cycles [RULE6]
               if (fetch_count_reg == 2'h1) begin
                  phase_reg <= RSM_RUN;
               end
            end

            RSM_RUN: begin
               // Stays until a new request
               phase_reg <= RSM_RUN;
            end

            default: begin
               phase_reg <= RSM_ACTIVE;
            end
         endcase
      end
   end

   // Delay counter, loaded as the active phase ends [RULE3]
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         count_reg <= 13'h0000;
      end else if (any_req) begin
         count_reg <= 13'h0000;
      end else if (phase_reg == RSM_ACTIVE) begin
         count_reg <= delay_load(long_delay_option_in);
      end else if (phase_reg == RSM_DELAY) begin
         count_reg <= count_reg - 13'h0001;
      end
   end

   // Fetch counter; cleared on restart so a cut fetch never resumes [RULE6]
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         fetch_count_reg <= 2'h0;
      end else if (any_req) begin
         fetch_count_reg <= 2'h0;
      end else if (delay_end) begin
         fetch_count_reg <= `RSM_FETCH_CYCLES;
      end else if (phase_reg == RSM_FETCH) begin
         fetch_count_reg <= fetch_count_reg - 2'h1;
      end
   end

   // Cause of the latest reset, kept for diagnosis
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         source_reg <= RSM_SRC_NONE;
      end else if (low_voltage_detector_in) begin
         source_reg <= RSM_SRC_LVD;
      end else if (wdg_hold) begin
         source_reg <= RSM_SRC_WDG;
      end else if (ext_req && phase_reg != RSM_ACTIVE) begin
         source_reg <= RSM_SRC_EXT;
      end
   end

   // Vector address walk: low byte then high byte [RULE7]
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         fetch_addr_reg <= `RSM_VECTOR_LOW_ADDR;
      end else if (phase_reg == RSM_FETCH && fetch_count_reg == `RSM_FETCH_CYCLES) begin
         fetch_addr_reg <= `RSM_VECTOR_HIGH_ADDR;
      end else if (phase_reg != RSM_FETCH) begin
         fetch_addr_reg <= `RSM_VECTOR_LOW_ADDR;
      end
   end

   // Follows the drive by one cycle, covering the pin's rise after release
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         drive_mask_reg <= 1'b1;
      end else begin
         drive_mask_reg <= pin_drive_reg;
      end
   end

   // Open-drain drive: low during internal requests and whole delay [RULE5] [RULE8]
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pin_drive_reg <= 1'b1;
      end else if (int_req) begin
         pin_drive_reg <= 1'b1;
      end else if (any_req) begin
         // Let go while only the outside holds the pin, so its release is seen
         pin_drive_reg <= 1'b0;
      end else begin
         pin_drive_reg <= holds_pin(phase_reg, count_reg);
      end
   end

   assign reset_pin_out = 1'b0;
   assign reset_pin_oe_out = pin_drive_reg;
   assign cpu_reset_out = (phase_reg != RSM_RUN);
   assign vector_fetch_out = (phase_reg == RSM_FETCH);
   assign fetch_addr_out = fetch_addr_reg;
   assign phase_out = phase_reg;
   assign source_out = source_reg;
endmodule

// File: rsm_chk.sv
// Checker of the reset phase sequencer
`timescale 1ns/1ps
`include "rsm_consts.svh"
module rsm_chk (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic reset_pin_in,
   input wire logic reset_pin_oe_out,
   input wire logic low_voltage_detector_in,
   input wire logic watchdog_underflow_in,
   input wire logic long_delay_option_in,
   input wire logic cpu_reset_out,
   input wire logic vector_fetch_out,
   input wire logic [15:0] fetch_addr_out,
   input wire rsm_pkg::rsm_phase_t phase_out,
   input wire rsm_pkg::rsm_source_t source_out
);
   import rsm_pkg::*;
   logic [12:0] dly_reg;
   // Counts delay cycles so the figure is checked at the fetch edge
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         dly_reg <= 13'h0;
      else
         dly_reg <= (phase_out == RSM_DELAY) ? dly_reg + 13'h1 : 13'h0;
   end
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);
   a_delay_pin_low: assert property (phase_out == RSM_DELAY |-> reset_pin_oe_out)
      else $error("pin released in delay");
   a_delay_len_exact: assert property (
      phase_out == RSM_FETCH && fetch_addr_out == 16'hFFFE |-> dly_reg ==
      (long_delay_option_in ? `RSM_LONG_DELAY_CYCLES : `RSM_SHORT_DELAY_CYCLES))
      else $error("delay length wrong");
   a_fetch_two_addr: assert property (
      phase_out == RSM_FETCH && fetch_addr_out == 16'hFFFE |=> phase_out == RSM_FETCH
      && vector_fetch_out && fetch_addr_out == 16'hFFFF ##1 phase_out == RSM_RUN)
      else $error("fetch order wrong");
   a_run_released: assert property (
      phase_out == RSM_RUN |-> !cpu_reset_out && !vector_fetch_out && !reset_pin_oe_out)
      else $error("cpu held in run");
   a_lvd_pin_low: assert property (
      low_voltage_detector_in |=> reset_pin_oe_out && phase_out == RSM_ACTIVE)
      else $error("lvd not driving pin");
   a_wdg_pin_pulse: assert property (
      $rose(watchdog_underflow_in) |=> reset_pin_oe_out [*8])
      else $error("watchdog pulse short");
   a_wdg_restart_src: assert property (
      $rose(watchdog_underflow_in) |=> source_out == RSM_SRC_WDG && phase_out == RSM_ACTIVE)
      else $error("watchdog restart wrong");
   a_ext_pin_reset: assert property (
      (!reset_pin_in && !reset_pin_oe_out) [*4] |-> ##[0:6] phase_out == RSM_ACTIVE)
      else $error("pin pulse ignored");
   c_fetch: cover property (phase_out == RSM_FETCH);
   c_long: cover property (dly_reg == 13'h1000);
   c_wdg: cover property ($rose(watchdog_underflow_in));
endmodule
bind rsm_reset_phase_sequencer rsm_chk u_chk (.sys_clk_in, .reset_n_in, .reset_pin_in,
   .reset_pin_oe_out, .low_voltage_detector_in, .watchdog_underflow_in,
   .long_delay_option_in, .cpu_reset_out, .vector_fetch_out, .fetch_addr_out,
   .phase_out, .source_out);

// File: rsm_ext_model.sv
// External reset circuit and pull-up on the shared reset pin
`timescale 1ns/1ps
module rsm_ext_model (
   input wire logic pull_low_in,
   input wire logic dev_oe_in,
   output logic pin_out
);
   // Weak pull-up wins only when nobody pulls low
   assign pin_out = !(pull_low_in || dev_oe_in);
endmodule

// File: reset_sequence_manager_tb.sv
// Self-checking bench of the reset phase sequencer
`timescale 1ns/1ps
module reset_sequence_manager_tb;
   import rsm_pkg::*;
   logic clk = 0, rst_n = 0, ext_low = 0, low_voltage_detector = 0, por = 0, wdg = 0, opt = 0;
   logic pin, oe, cpu_rst, vf, pdat;
   logic [15:0] addr;
   logic [31:0] seed = 32'h4F0B;
   logic [15:0] exp_q[$];
   rsm_phase_t ph;
   rsm_source_t src;
   int n_fail = 0, cmp_count = 0;
   initial forever #12.5 clk = ~clk;
   rsm_ext_model ext (.pull_low_in(ext_low), .dev_oe_in(oe), .pin_out(pin));
   rsm_reset_phase_sequencer uut (.sys_clk_in(clk), .reset_n_in(rst_n), .reset_pin_in(pin),
      .reset_pin_out(pdat), .reset_pin_oe_out(oe), .low_voltage_detector_in(low_voltage_detector),
      .lvd_power_on_in(por), .watchdog_underflow_in(wdg), .long_delay_option_in(opt),
      .cpu_reset_out(cpu_rst), .vector_fetch_out(vf), .fetch_addr_out(addr),
      .phase_out(ph), .source_out(src));
   function automatic int rnd(int m);
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0] % m;
   endfunction
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmp(logic [31:0] got, logic [31:0] exp, string what);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic drv();
      @(posedge clk);
      #2;
   endtask
   // Sequence model: delay length then fetch addresses in order
   task automatic run_seq(int lim);
      int c = 0;
      exp_q = {16'hFFFE, 16'hFFFF};
      while (ph !== RSM_DELAY && c < 200) begin
         @(negedge clk);
         c++;
      end
      if (c == 200) begin
         n_fail++;
         $display("[FAIL] %0t delay phase never reached", $time);
         return;
      end
      for (c = 0; ph === RSM_DELAY && c < 5000; c++) begin
         cmp({oe, pdat, pin}, 3'b100, "pin in delay");
         @(negedge clk);
      end
      cmp(c, lim, "delay length");
      while (exp_q.size() > 0) begin
         cmp({ph, vf, addr}, {RSM_FETCH, 1'b1, exp_q.pop_front()}, "fetch");
         @(negedge clk);
      end
      cmp({ph, cpu_rst}, {RSM_RUN, 1'b0}, "run");
      $display("sequence done at %0t", $time);
   endtask
   initial begin
      repeat (12) drv();
      rst_n = 1;
      run_seq(256);
      drv();
      opt = 1;
      ext_low = 1;
      repeat (4 + rnd(8)) drv();
      ext_low = 0;
      cmp(src, RSM_SRC_EXT, "ext source");
      run_seq(4096);
      drv();
      opt = 0;
      low_voltage_detector = 1;
      por = rnd(2) == 1;
      repeat (1 + rnd(20)) drv();
      cmp({ph, oe, src}, {RSM_ACTIVE, 1'b1, RSM_SRC_LVD}, "lvd");
      $display("lvd test done at %0t", $time);
      low_voltage_detector = 0;
      repeat (100) drv();
      wdg = 1;
      drv();
      wdg = 0;
      cmp({ph, src, oe}, {RSM_ACTIVE, RSM_SRC_WDG, 1'b1}, "wdg restart");
      run_seq(256);
      print_verdict();
   end
endmodule
